// [verilog/acrb_bank.sv]
/*
  acrb_bank: configuration register bank with register read/write command
  decode and the integrity trailer on the transmit byte stream.
  Assumes a byte receiver and transmitter on the same clock: received
  command bytes arrive as one-cycle pulses, transmitted bytes leave by a
  valid/ready handshake. The converter core asks for a result transfer.
*/
`timescale 1ns/1ps
module acrb_bank
  import acrb_pkg::*;
(
  input  wire logic        CLK_SYS_IN,
  input  wire logic        NRST_IN,
  input  wire logic [7:0]  RX_BYTE_IN,
  input  wire logic        RX_VALID_IN,
  output logic      [7:0]  TX_BYTE_OUT,
  output logic             TX_VALID_OUT,
  input  wire logic        TX_READY_IN,
  input  wire logic        CONV_SEND_IN,
  input  wire logic [15:0] CONV_DATA_IN,
  input  wire logic [7:0]  CONV_COUNT_IN,
  input  wire logic        NEW_RESULT_IN,
  input  wire logic        POWERDOWN_IN,
  output logic      [7:0]  CFG0_OUT,
  output logic      [7:0]  CFG1_OUT,
  output logic      [7:0]  CFG2_OUT,
  output logic      [7:0]  CFG3_OUT,
  output logic      [7:0]  CFG4_OUT,
  output logic             FILTER_RESET_OUT
);

  typedef enum logic [2:0] {
    ACRB_IDLE  = 3'b001,
    ACRB_SEND  = 3'b010,
    ACRB_TRAIL = 3'b100
  } acrb_state_type;

  typedef struct packed {
    acrb_state_type                      state;
    logic [ACRB_NUM_REGS-1:0][7:0]       regs;
    logic                                wr_wait;
    logic [2:0]                          wr_addr;
    logic [ACRB_BUF_DEPTH-1:0][7:0]      buf_bytes;
    logic [2:0]                          len;
    logic [2:0]                          idx;
    logic                                crc_on;
    logic [15:0]                         crc;
    logic [7:0]                          tx_byte;
    logic                                filter_reset;
  } acrb_st_type;

  acrb_st_type st_reg;
  acrb_st_type st_next;
  logic [15:0] crc_upd;

  // the check word runs over every data byte as it is handed over
  acrb_crc16 u_crc (
    .crc_in  (st_reg.crc),
    .byte_in (st_reg.tx_byte),
    .crc_out (crc_upd)
  );

  // read value of one address; the new-result flag is live, not stored
  function automatic logic [7:0] read_value(input logic [2:0] a,
                                            input acrb_st_type s,
                                            input logic flag);
    logic [7:0] v;
    v = ACRB_UNMAPPED_READ;
    if (a < 3'(ACRB_NUM_REGS)) begin
      v = s.regs[a];
    end
    if (a == ACRB_ADDR_FLAGS_INTEG) begin
      v[ACRB_NEW_RESULT_BIT] = flag;
    end
    return v;
  endfunction

  function automatic logic [7:0] write_mask(input logic [2:0] a);
    logic [7:0] m;
    unique case (a)
      ACRB_ADDR_INPUT_GAIN:   m = ACRB_WMASK_REG0;
      ACRB_ADDR_RATE_MODE:    m = ACRB_WMASK_REG1;
      ACRB_ADDR_FLAGS_INTEG:  m = ACRB_WMASK_REG2;
      ACRB_ADDR_CURRENT_AUTO: m = ACRB_WMASK_REG3;
      ACRB_ADDR_GENERAL_PIN:  m = ACRB_WMASK_REG4;
      default:                m = 8'h00;
    endcase
    return m;
  endfunction

  // command decode, staging of a transfer and byte sequencing
  always_comb begin
    logic [ACRB_BUF_DEPTH-1:0][7:0] lb;
    logic [2:0]                     k;
    logic [2:0]                     data_n;
    logic [1:0]                     integ;
    logic                           cnt_en;
    logic                           start;
    lb     = '0;
    k      = 3'h0;
    data_n = 3'h0;
    start  = 1'b0;
    integ  = st_reg.regs[ACRB_ADDR_FLAGS_INTEG][ACRB_INTEG_MSB:ACRB_INTEG_LSB];
    cnt_en = st_reg.regs[ACRB_ADDR_FLAGS_INTEG][ACRB_COUNTER_EN_BIT];
    st_next = st_reg;
    st_next.filter_reset = 1'b0;
    // power-down has no path into the registers on purpose
    if (RX_VALID_IN) begin
      if (st_reg.wr_wait) begin
        st_next.wr_wait = 1'b0;
        if (st_reg.wr_addr < 3'(ACRB_NUM_REGS)) begin
          st_next.regs[st_reg.wr_addr] = RX_BYTE_IN & write_mask(st_reg.wr_addr);
          st_next.filter_reset = (st_reg.wr_addr != ACRB_ADDR_GENERAL_PIN);
        end
      end else if (RX_BYTE_IN[7:4] == ACRB_CMD_REG_WRITE) begin
        st_next.wr_wait = 1'b1;
        st_next.wr_addr = RX_BYTE_IN[3:1];
      end
    end
    // result transfer wins over a register read in the same cycle
    if (st_reg.state == ACRB_IDLE) begin
      if (CONV_SEND_IN) begin
        start = 1'b1;
        if (cnt_en) begin
          lb[k] = CONV_COUNT_IN;
          k = k + 3'h1;
        end
        lb[k] = CONV_DATA_IN[7:0];
        lb[k + 3'h1] = CONV_DATA_IN[15:8];
        k = k + 3'h2;
      end else if (RX_VALID_IN && !st_reg.wr_wait &&
                   RX_BYTE_IN[7:4] == ACRB_CMD_REG_READ) begin
        start = 1'b1;
        lb[0] = read_value(RX_BYTE_IN[3:1], st_reg, NEW_RESULT_IN);
        k = ACRB_LEN_ONE;
      end
    end
    data_n = k;
    // inverted copies follow the data bytes directly
    if (integ == ACRB_INTEG_INVERT) begin
      for (int i = 0; i < ACRB_BUF_DEPTH / 2; i++) begin
        if (3'(i) < data_n) begin
          lb[data_n + 3'(i)] = ~lb[i];
        end
      end
      k = data_n << 1;
    end
    unique case (st_reg.state)
      ACRB_IDLE: begin
        if (start) begin
          st_next.state     = ACRB_SEND;
          st_next.buf_bytes = lb;
          st_next.len       = k;
          st_next.idx       = 3'h0;
          st_next.tx_byte   = lb[0];
          st_next.crc       = ACRB_CRC_INIT;
          st_next.crc_on    = (integ == ACRB_INTEG_CRC16);
        end
      end
      ACRB_SEND: begin
        if (TX_READY_IN) begin
          st_next.crc = crc_upd;
          if (st_reg.idx == st_reg.len - 3'h1) begin
            st_next.idx = 3'h0;
            if (st_reg.crc_on) begin
              st_next.state   = ACRB_TRAIL;
              st_next.tx_byte = crc_upd[7:0];
            end else begin
              st_next.state   = ACRB_IDLE;
            end
          end else begin
            st_next.idx     = st_reg.idx + 3'h1;
            st_next.tx_byte = st_reg.buf_bytes[st_reg.idx + 3'h1];
          end
        end
      end
      ACRB_TRAIL: begin
        // exactly two check bytes, low byte first
        if (TX_READY_IN) begin
          if (st_reg.idx == 3'h0) begin
            st_next.idx     = 3'h1;
            st_next.tx_byte = st_reg.crc[15:8];
          end else begin
            st_next.idx     = 3'h0;
            st_next.state   = ACRB_IDLE;
          end
        end
      end
    endcase
  end

  // single state register, synchronous reset to the documented defaults
  always_ff @(posedge CLK_SYS_IN) begin
    if (!NRST_IN) begin
      st_reg        <= '0;
      st_reg.regs   <= {ACRB_NUM_REGS{ACRB_REG_RESET}};
      st_reg.state  <= ACRB_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // field layout of 00h is the stored byte itself
  assign CFG0_OUT         = st_reg.regs[ACRB_ADDR_INPUT_GAIN];
  assign CFG1_OUT         = st_reg.regs[ACRB_ADDR_RATE_MODE];
  assign CFG2_OUT         = st_reg.regs[ACRB_ADDR_FLAGS_INTEG];
  assign CFG3_OUT         = st_reg.regs[ACRB_ADDR_CURRENT_AUTO];
  assign CFG4_OUT         = st_reg.regs[ACRB_ADDR_GENERAL_PIN];
  assign TX_BYTE_OUT      = st_reg.tx_byte;
  assign TX_VALID_OUT     = (st_reg.state != ACRB_IDLE);
  assign FILTER_RESET_OUT = st_reg.filter_reset;

  // checks
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!NRST_IN);

  logic wr_data_hit;
  logic rd_start;
  assign wr_data_hit = RX_VALID_IN && st_reg.wr_wait;
  assign rd_start = (st_reg.state == ACRB_IDLE) && !CONV_SEND_IN && RX_VALID_IN &&
                    !st_reg.wr_wait && RX_BYTE_IN[7:4] == ACRB_CMD_REG_READ;

  a_reset_clears: assert property (@(posedge CLK_SYS_IN) disable iff (1'b0)
    !NRST_IN |=> (CFG0_OUT | CFG1_OUT | CFG2_OUT | CFG3_OUT | CFG4_OUT) == 8'h00)
    else $error("registers not cleared by reset");
  a_unmapped_write: assert property (wr_data_hit && st_reg.wr_addr > 3'h4
    |=> $stable(st_reg.regs) && !FILTER_RESET_OUT)
    else $error("write to missing register changed state");
  a_unmapped_read: assert property (rd_start && RX_BYTE_IN[3:1] > 3'h4
    |=> TX_VALID_OUT && TX_BYTE_OUT == 8'h00)
    else $error("missing register did not read zero");
  a_filter_reset_cause: assert property (wr_data_hit && st_reg.wr_addr < 3'h4
    |=> FILTER_RESET_OUT ##1 !FILTER_RESET_OUT)
    else $error("filter reset pulse wrong");
  a_pin_write_quiet: assert property (wr_data_hit && st_reg.wr_addr == 3'h4
    |=> !FILTER_RESET_OUT && CFG4_OUT == ($past(RX_BYTE_IN) & 8'h7f))
    else $error("pin register write wrong");
  a_fixed_zero_bits: assert property (!CFG3_OUT[1] && !CFG4_OUT[7])
    else $error("fixed zero bit set");
  a_powerdown_keeps: assert property (POWERDOWN_IN && !wr_data_hit
    |=> $stable(st_reg.regs))
    else $error("register changed in power-down");
  // a stalled host may hold a check byte, so only the hand-over edge is pinned
  a_trail_follows: assert property (st_reg.state == ACRB_SEND && TX_READY_IN &&
    st_reg.idx == st_reg.len - 3'h1 && st_reg.crc_on
    |=> TX_VALID_OUT && st_reg.state == ACRB_TRAIL && st_reg.idx == 3'h0 &&
        TX_BYTE_OUT == st_reg.crc[7:0])
    else $error("check bytes not adjacent");
  a_lsb_first: assert property ((st_reg.state == ACRB_IDLE) && CONV_SEND_IN &&
    !CFG2_OUT[6] |=> TX_BYTE_OUT == $past(CONV_DATA_IN[7:0]))
    else $error("low data byte not first");
  a_invert_len: assert property ((st_reg.state == ACRB_IDLE) && CONV_SEND_IN &&
    CFG2_OUT[5:4] == 2'h1 |=> st_reg.len == (CFG2_OUT[6] ? 3'h6 : 3'h4))
    else $error("inverted transfer length wrong");
  a_none_no_extra: assert property ((st_reg.state == ACRB_IDLE) && rd_start &&
    CFG2_OUT[5:4] == 2'h0 |=> st_reg.len == 3'h1 && !st_reg.crc_on)
    else $error("extra words with integrity off");
  a_tx_hold: assert property (TX_VALID_OUT && !TX_READY_IN |=> $stable(TX_BYTE_OUT))
    else $error("transmit byte moved while stalled");

  c_reg_read:  cover property (rd_start ##1 TX_VALID_OUT);
  c_crc_trail: cover property (st_reg.state == ACRB_TRAIL && st_reg.idx == 3'h1);
  c_inverted:  cover property (st_reg.state == ACRB_SEND && st_reg.len == 3'h6);
  c_wr_filter: cover property (FILTER_RESET_OUT);

endmodule

// [verilog/acrb_pkg.sv]
/*
  acrb_pkg: constants shared by the configuration register bank of the
  delta-sigma converter: register addresses, field positions, write masks,
  command codes, integrity-mode codes and check-word constants.
  Assumes nothing of its surroundings.
*/
package acrb_pkg;

  // register addresses, three address bits carried in the command byte
  localparam logic [2:0] ACRB_ADDR_INPUT_GAIN   = 3'h0;
  localparam logic [2:0] ACRB_ADDR_RATE_MODE    = 3'h1;
  localparam logic [2:0] ACRB_ADDR_FLAGS_INTEG  = 3'h2;
  localparam logic [2:0] ACRB_ADDR_CURRENT_AUTO = 3'h3;
  localparam logic [2:0] ACRB_ADDR_GENERAL_PIN  = 3'h4;
  localparam int         ACRB_NUM_REGS          = 5;

  // value of every register after reset
  localparam logic [7:0] ACRB_REG_RESET = 8'h00;
  // value answered for an address with no register behind it
  localparam logic [7:0] ACRB_UNMAPPED_READ = 8'h00;

  // register 00h fields
  localparam int ACRB_INPUT_SELECT_MSB = 7;
  localparam int ACRB_INPUT_SELECT_LSB = 4;
  localparam int ACRB_GAIN_MSB         = 3;
  localparam int ACRB_GAIN_LSB         = 1;
  localparam int ACRB_AMP_BYPASS_BIT   = 0;

  // register 02h fields
  localparam int ACRB_NEW_RESULT_BIT   = 7;
  localparam int ACRB_COUNTER_EN_BIT   = 6;
  localparam int ACRB_INTEG_MSB        = 5;
  localparam int ACRB_INTEG_LSB        = 4;

  // writable bits per register; zero bits read back as zero, except bit 7 of 02h, which reads the live new-result flag
  localparam logic [7:0] ACRB_WMASK_REG0 = 8'hff;
  localparam logic [7:0] ACRB_WMASK_REG1 = 8'hff;
  localparam logic [7:0] ACRB_WMASK_REG2 = 8'h7f;
  localparam logic [7:0] ACRB_WMASK_REG3 = 8'hfd;
  localparam logic [7:0] ACRB_WMASK_REG4 = 8'h7f;

  // command byte upper nibble, address in bits 3:1
  localparam logic [3:0] ACRB_CMD_REG_READ  = 4'h2;
  localparam logic [3:0] ACRB_CMD_REG_WRITE = 4'h4;

  // integrity-mode field codes
  localparam logic [1:0] ACRB_INTEG_NONE   = 2'h0;
  localparam logic [1:0] ACRB_INTEG_INVERT = 2'h1;
  localparam logic [1:0] ACRB_INTEG_CRC16  = 2'h2;

  // check word generator
  localparam logic [15:0] ACRB_CRC_POLY = 16'h1021;
  localparam logic [15:0] ACRB_CRC_INIT = 16'hffff;

  // transmit staging depth: counter, two data bytes and their inverses
  localparam int         ACRB_BUF_DEPTH = 6;
  localparam logic [2:0] ACRB_LEN_ONE   = 3'h1;

endpackage

// [verilog/acrb_crc16.sv]
/*
  acrb_crc16: one-byte update of the 16-bit check word, msb-first shift.
  Assumes the caller holds the running value in its own register.
*/
`timescale 1ns/1ps
module acrb_crc16
  import acrb_pkg::*;
(
  input  wire logic [15:0] crc_in,
  input  wire logic [7:0]  byte_in,
  output logic      [15:0] crc_out
);

  // eight shift steps unrolled by the loop, purely combinational
  always_comb begin
    logic [15:0] c;
    c = crc_in ^ {byte_in, 8'h00};
    for (int i = 0; i < 8; i++) begin
      c = c[15] ? ((c << 1) ^ ACRB_CRC_POLY) : (c << 1);
    end
    crc_out = c;
  end

endmodule

// [sim/acrb_host.sv]
/*
  acrb_host: host-side model of the byte link; it takes transmitted bytes
  into a queue and may stall at random.
  Assumes the bench seeds the random source and reads got_q.
*/
`timescale 1ns/1ps
module acrb_host (
  input  wire logic       clk_in,
  input  wire logic [7:0] byte_in,
  input  wire logic       valid_in,
  input  wire logic       slow_in,
  output logic            ready_out
);
  logic [7:0] got_q[$];

  initial ready_out = 1'b0;

  // bytes kept in arrival order, so word order is seen as sent
  always @(posedge clk_in) begin
    if (valid_in && ready_out) got_q.push_back(byte_in);
    ready_out <= #1 slow_in ? 1'($urandom % 2) : 1'b1;
  end
endmodule

// [sim/testbench.sv]
/*
  testbench: register bank bench with a queue model of registers and of
  the transmit stream, compared at every write, read and result transfer.
  Assumes acrb_pkg and the acrb_bank design with the host model beside it.
*/
`timescale 1ns/1ps
module testbench
  import acrb_pkg::*;
;
  localparam logic [7:0] WM [5] = '{ACRB_WMASK_REG0, ACRB_WMASK_REG1, ACRB_WMASK_REG2,
                                     ACRB_WMASK_REG3, ACRB_WMASK_REG4};
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  rx_byte = 8'h00;
  logic        rx_valid = 1'b0;
  logic        conv_send = 1'b0;
  logic        new_res = 1'b0;
  logic        pdown = 1'b0;
  logic        slow = 1'b0;
  logic [15:0] conv_data = 16'h0000;
  logic [7:0]  conv_cnt = 8'h00;
  logic [7:0]  tx_byte;
  logic        tx_valid;
  logic        tx_ready;
  logic        filt;
  wire  [7:0]  cfg [5];
  logic [7:0]  mdl [8] = '{default: 8'h00};
  logic [7:0]  exp_q[$];
  int          num_errors = 0;
  int          n_checks = 0;
  int          cyc = 0;

  acrb_bank u_dut (.CLK_SYS_IN(clk), .NRST_IN(nrst), .RX_BYTE_IN(rx_byte),
    .RX_VALID_IN(rx_valid), .TX_BYTE_OUT(tx_byte), .TX_VALID_OUT(tx_valid),
    .TX_READY_IN(tx_ready), .CONV_SEND_IN(conv_send), .CONV_DATA_IN(conv_data),
    .CONV_COUNT_IN(conv_cnt), .NEW_RESULT_IN(new_res), .POWERDOWN_IN(pdown),
    .CFG0_OUT(cfg[0]), .CFG1_OUT(cfg[1]), .CFG2_OUT(cfg[2]), .CFG3_OUT(cfg[3]),
    .CFG4_OUT(cfg[4]), .FILTER_RESET_OUT(filt));
  acrb_host u_host (.clk_in(clk), .byte_in(tx_byte), .valid_in(tx_valid),
    .slow_in(slow), .ready_out(tx_ready));

  // clock and a hang guard well above the expected run length
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      stop_test();
    end
  end

  task stop_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task chk_byte(string nm, logic [7:0] e, logic [7:0] g);
    n_checks++;
    if (e !== g) begin
      num_errors++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask

  task chk_cnt(string nm, int e, int g);
    n_checks++;
    if (e != g) begin
      num_errors++;
      $display("unexpected %s exp %0d got %0d", nm, e, g);
    end
  endtask

  // reference check word, msb-first over each byte
  function automatic logic [15:0] crc_upd(logic [15:0] c, logic [7:0] b);
    logic fb;
    for (int i = 7; i >= 0; i--) begin
      fb = c[15] ^ b[i];
      c = {c[14:0], 1'b0} ^ (fb ? ACRB_CRC_POLY : 16'h0000);
    end
    return c;
  endfunction

  // expected stream: data bytes, then the trailer of the active mode
  task build(logic [7:0] b[$], logic [1:0] m);
    logic [15:0] c;
    c = ACRB_CRC_INIT;
    foreach (b[i]) begin
      exp_q.push_back(b[i]);
      c = crc_upd(c, b[i]);
    end
    if (m == ACRB_INTEG_INVERT) foreach (b[i]) exp_q.push_back(~b[i]);
    if (m == ACRB_INTEG_CRC16) exp_q = {exp_q, c[7:0], c[15:8]};
  endtask

  task send(logic [7:0] b);
    @(posedge clk);
    #1 rx_byte = b;
    rx_valid = 1'b1;
    @(posedge clk);
    #1 rx_valid = 1'b0;
  endtask

  // collect one transfer; with the host never stalling it must be gapless
  task expect_xfer();
    int nv;
    nv = int'(tx_valid === 1'b1);
    for (int i = 0; i < 80; i++) begin
      @(posedge clk);
      #2;
      if (tx_valid === 1'b1) nv++;
      else if (nv > 0) break;
    end
    chk_cnt("tx length", exp_q.size(), u_host.got_q.size());
    if (!slow) chk_cnt("tx busy cycles", exp_q.size(), nv);
    foreach (exp_q[i]) chk_byte("tx byte", exp_q[i], u_host.got_q[i]);
    exp_q.delete();
    u_host.got_q.delete();
  endtask

  task wr(logic [2:0] a, logic [7:0] d);
    send({ACRB_CMD_REG_WRITE, a, 1'b0});
    pdown = 1'($urandom);
    send(d);
    if (a < 5) mdl[a] = d & WM[a];
    chk_byte("filter reset", {7'h0, a < 4}, {7'h0, filt});
    for (int r = 0; r < 5; r++) chk_byte("cfg", mdl[r], cfg[r]);
  endtask

  task rd(logic [2:0] a);
    logic [7:0] v;
    new_res = 1'($urandom);
    v = (a < 5) ? mdl[a] : ACRB_UNMAPPED_READ;
    if (a == ACRB_ADDR_FLAGS_INTEG) v[7] = new_res;
    send({ACRB_CMD_REG_READ, a, 1'b0});
    build('{v}, mdl[2][5:4]);
    expect_xfer();
  endtask

  task cv();
    conv_data = 16'($urandom);
    conv_cnt = 8'($urandom);
    @(posedge clk);
    #1 conv_send = 1'b1;
    @(posedge clk);
    #1 conv_send = 1'b0;
    if (mdl[2][6]) build('{conv_cnt, conv_data[7:0], conv_data[15:8]}, mdl[2][5:4]);
    else build('{conv_data[7:0], conv_data[15:8]}, mdl[2][5:4]);
    expect_xfer();
  endtask

  // main sequence: reset, map sweep, every mode with both host speeds
  initial begin
    logic [7:0] d;
    void'($urandom(61185));
    repeat (8) @(posedge clk);
    #1 nrst = 1'b1;
    for (int r = 0; r < 5; r++) chk_byte("reset cfg", ACRB_REG_RESET, cfg[r]);
    for (int a = 0; a < 8; a++) rd(3'(a));
    for (int p = 0; p < 2; p++)
      for (int m = 0; m < 4; m++)
        for (int e = 0; e < 2; e++) begin
          slow = p[0];
          wr(ACRB_ADDR_FLAGS_INTEG, {1'($urandom), e[0], m[1:0], 4'($urandom)});
          for (int a = 0; a < 8; a++) begin
            d = 8'($urandom);
            if (a == 0 && d[7:6] == 2'b10) d[3:0] = {3'($urandom % 3), 1'b1};
            if (a != 2) wr(3'(a), d);
          end
          rd(3'($urandom % 8));
          rd(ACRB_ADDR_FLAGS_INTEG);
          cv();
        end
    @(posedge clk);
    #1 nrst = 1'b0;
    @(posedge clk);
    #1 nrst = 1'b1;
    mdl = '{default: 8'h00};
    for (int r = 0; r < 5; r++) chk_byte("reset cfg", ACRB_REG_RESET, cfg[r]);
    rd(ACRB_ADDR_INPUT_GAIN);
    stop_test();
  end
endmodule
